// ### hdl/igcp_pkg.sv
// Constants for the indexed GPIO configuration port.
// Assumes an I/O cycle interface with one-cycle read and write strobes on clk.
//
// Overview of operation
// - Two back-to-back writes of 87h to the index port at 2Eh unlock configuration access.
// - Writing AAh to the index port locks configuration access again.
// - The index port at 2Eh is write-only and holds the target register number.
// - The data port at 2Fh reads and writes the register chosen by the index.
// - Registers F0h to F2h reach the pin bank only while device 09 is selected.
// - A set direction bit makes its pin an input; direction resets to FFh.
// - Value bits of output pins are readable and writable; value resets to 00h.
// - Value bits of input pins read the sampled pin and ignore writes.
// - A set polarity bit inverts the pin in both directions; polarity resets to 00h.
// - A cleared polarity bit passes the level unchanged in both directions.
package igcp_pkg;
    localparam logic [7:0] IGCP_ADDR_INDEX   = 8'h2E;
    localparam logic [7:0] IGCP_ADDR_DATA    = 8'h2F;
    localparam logic [7:0] IGCP_KEY_UNLOCK   = 8'h87;
    localparam logic [7:0] IGCP_KEY_LOCK     = 8'hAA;
    localparam logic [7:0] IGCP_REG_LDEV     = 8'h07;
    localparam logic [7:0] IGCP_REG_DIR      = 8'hF0;
    localparam logic [7:0] IGCP_REG_VALUE    = 8'hF1;
    localparam logic [7:0] IGCP_REG_POL      = 8'hF2;
    localparam logic [7:0] IGCP_LDEV_GPIO    = 8'h09;
    localparam logic [7:0] IGCP_RST_DIR      = 8'hFF;
    localparam logic [7:0] IGCP_RST_VALUE    = 8'h00;
    localparam logic [7:0] IGCP_RST_POL      = 8'h00;
    localparam logic [7:0] IGCP_RST_LDEV     = 8'h00;
    localparam logic [7:0] IGCP_RST_INDEX    = 8'h00;
    localparam logic [7:0] IGCP_READ_IDLE    = 8'hFF;

    typedef enum logic [2:0] {
        IGCP_LOCKED = 3'h1,
        IGCP_HALF   = 3'h2,
        IGCP_OPEN   = 3'h4
    } igcp_state_t;
endpackage : igcp_pkg

// ### hdl/indexed_gpio_config_port.sv
// Indexed GPIO configuration port with an eight-pin bank.
// Assumes one-cycle ioWrite/ioRead strobes synchronous to clk; pins are asynchronous.
`timescale 1ns/1ps
module indexed_gpio_config_port #(
    parameter int PINS = 8
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [7:0]       ioAddr,
    input  wire logic             ioWrite,
    input  wire logic             ioRead,
    input  wire logic [7:0]       ioWrData,
    output logic      [7:0]       ioRdData,
    output logic                  cfgUnlocked,
    input  wire logic [PINS-1:0]  generalPinsIn,
    output logic      [PINS-1:0]  generalPinsOut,
    output logic      [PINS-1:0]  generalPinsOe
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser: three stages, a change counts once stages two and three agree

    logic [PINS-1:0] sync1Reg, sync2Reg, sync3Reg, pinLevelReg;
    logic [PINS-1:0] pinLevelNext;

    always_comb begin
        pinLevelNext = pinLevelReg;
        for (int i = 0; i < PINS; i++) begin
            if (sync2Reg[i] == sync3Reg[i]) begin
                pinLevelNext[i] = sync3Reg[i];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1Reg    <= '0;
            sync2Reg    <= '0;
            sync3Reg    <= '0;
            pinLevelReg <= '0;
        end else begin
            sync1Reg    <= generalPinsIn;
            sync2Reg    <= sync1Reg;
            sync3Reg    <= sync2Reg;
            pinLevelReg <= pinLevelNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Unlock sequencer and index

    igcp_pkg::igcp_state_t stateReg, stateNext;
    logic [7:0] indexReg, indexNext;

    wire logic idxWr  = ioWrite && (ioAddr == igcp_pkg::IGCP_ADDR_INDEX);
    wire logic dataWr = ioWrite && (ioAddr == igcp_pkg::IGCP_ADDR_DATA);
    wire logic dataRd = ioRead  && (ioAddr == igcp_pkg::IGCP_ADDR_DATA);

    always_comb begin
        stateNext = stateReg;
        indexNext = indexReg;
        case (stateReg)
            igcp_pkg::IGCP_LOCKED: begin
                if (idxWr && ioWrData == igcp_pkg::IGCP_KEY_UNLOCK) begin
                    stateNext = igcp_pkg::IGCP_HALF;
                end
            end
            igcp_pkg::IGCP_HALF: begin
                // Any other index write breaks the pair; data cycles do not
                if (idxWr) begin
                    stateNext = (ioWrData == igcp_pkg::IGCP_KEY_UNLOCK) ?
                                igcp_pkg::IGCP_OPEN : igcp_pkg::IGCP_LOCKED;
                end
            end
            igcp_pkg::IGCP_OPEN: begin
                if (idxWr) begin
                    if (ioWrData == igcp_pkg::IGCP_KEY_LOCK) begin
                        stateNext = igcp_pkg::IGCP_LOCKED;
                    end else begin
                        indexNext = ioWrData;
                    end
                end
            end
            default: stateNext = igcp_pkg::IGCP_LOCKED;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stateReg <= igcp_pkg::IGCP_LOCKED;
            indexReg <= igcp_pkg::IGCP_RST_INDEX;
        end else begin
            stateReg <= stateNext;
            indexReg <= indexNext;
        end
    end

    wire logic open    = (stateReg == igcp_pkg::IGCP_OPEN);
    assign cfgUnlocked = open;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic [7:0]      ldevReg, ldevNext;
    logic [PINS-1:0] dirReg, dirNext, valReg, valNext, polReg, polNext;
    logic [7:0]      rdReg, rdNext;

    // Pin registers only respond while the GPIO device is selected
    function automatic logic pinSel(input logic [7:0] idx, input logic [7:0] ldev,
                                    input logic [7:0] target);
        pinSel = (ldev == igcp_pkg::IGCP_LDEV_GPIO) && (idx == target);
    endfunction : pinSel

    wire logic cfgWr = open && dataWr;
    wire logic cfgRd = open && dataRd;

    // Input bits read the pin through the polarity stage
    wire logic [PINS-1:0] valView = (dirReg & (pinLevelReg ^ polReg)) | (~dirReg & valReg);

    always_comb begin
        ldevNext = ldevReg;
        dirNext  = dirReg;
        valNext  = valReg;
        polNext  = polReg;
        rdNext   = rdReg;
        if (cfgWr) begin
            if (indexReg == igcp_pkg::IGCP_REG_LDEV) begin
                ldevNext = ioWrData;
            end
            if (pinSel(indexReg, ldevReg, igcp_pkg::IGCP_REG_DIR)) begin
                dirNext = ioWrData[PINS-1:0];
            end
            if (pinSel(indexReg, ldevReg, igcp_pkg::IGCP_REG_VALUE)) begin
                valNext = (dirReg & valReg) | (~dirReg & ioWrData[PINS-1:0]);
            end
            if (pinSel(indexReg, ldevReg, igcp_pkg::IGCP_REG_POL)) begin
                polNext = ioWrData[PINS-1:0];
            end
        end
        if (cfgRd) begin
            rdNext = '0;
            if (indexReg == igcp_pkg::IGCP_REG_LDEV) begin
                rdNext = ldevReg;
            end else if (pinSel(indexReg, ldevReg, igcp_pkg::IGCP_REG_DIR)) begin
                rdNext[PINS-1:0] = dirReg;
            end else if (pinSel(indexReg, ldevReg, igcp_pkg::IGCP_REG_VALUE)) begin
                rdNext[PINS-1:0] = valView;
            end else if (pinSel(indexReg, ldevReg, igcp_pkg::IGCP_REG_POL)) begin
                rdNext[PINS-1:0] = polReg;
            end
        end else if (dataRd) begin
            // A locked port reads like an undriven bus
            rdNext = igcp_pkg::IGCP_READ_IDLE;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ldevReg <= igcp_pkg::IGCP_RST_LDEV;
            dirReg  <= igcp_pkg::IGCP_RST_DIR[PINS-1:0];
            valReg  <= igcp_pkg::IGCP_RST_VALUE[PINS-1:0];
            polReg  <= igcp_pkg::IGCP_RST_POL[PINS-1:0];
            rdReg   <= igcp_pkg::IGCP_READ_IDLE;
        end else begin
            ldevReg <= ldevNext;
            dirReg  <= dirNext;
            valReg  <= valNext;
            polReg  <= polNext;
            rdReg   <= rdNext;
        end
    end

    assign ioRdData = rdReg;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drive; polarity applied on the way out as well

    logic [PINS-1:0] pinOutReg, pinOutNext, pinOeReg, pinOeNext;

    // Built from the next register values so the pins move with the registers
    always_comb begin
        pinOutNext = valNext ^ polNext;
        pinOeNext  = ~dirNext;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinOutReg <= '0;
            pinOeReg  <= '0;
        end else begin
            pinOutReg <= pinOutNext;
            pinOeReg  <= pinOeNext;
        end
    end

    assign generalPinsOut = pinOutReg;
    assign generalPinsOe  = pinOeReg;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    unlock_pair_a: assert property (@(posedge clk) disable iff (sys_rst)
        !open ##1 open |-> $past(idxWr) && $past(ioWrData) == igcp_pkg::IGCP_KEY_UNLOCK)
        else $error("unlock without key write");

    lock_key_a: assert property (@(posedge clk) disable iff (sys_rst)
        open && idxWr && ioWrData == igcp_pkg::IGCP_KEY_LOCK |=> !open)
        else $error("lock key ignored");

    index_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !idxWr |=> $stable(indexReg))
        else $error("index changed without write");

    locked_ignore_a: assert property (@(posedge clk) disable iff (sys_rst)
        !open |=> $stable(dirReg) && $stable(polReg) && $stable(ldevReg))
        else $error("register changed while locked");

    device_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        ldevReg != igcp_pkg::IGCP_LDEV_GPIO |=> $stable(dirReg) && $stable(polReg))
        else $error("pin register changed with other device");

    input_value_a: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 ($past(dirReg) & (valReg ^ $past(valReg))) == '0)
        else $error("input value bit written");

    data_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        cfgRd && pinSel(indexReg, ldevReg, igcp_pkg::IGCP_REG_DIR) |=>
        ioRdData[PINS-1:0] == $past(dirReg))
        else $error("direction read wrong");

    pin_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
        generalPinsOut == (valReg ^ polReg)
        && generalPinsOe == ~dirReg)
        else $error("pin drive mismatch");

    // Lock state: a locked port reads idle and keeps every register
    locked_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        dataRd && !open |=> ioRdData == igcp_pkg::IGCP_READ_IDLE)
        else $error("locked read not idle");

    half_break_a: assert property (@(posedge clk) disable iff (sys_rst)
        stateReg == igcp_pkg::IGCP_HALF && idxWr && ioWrData != igcp_pkg::IGCP_KEY_UNLOCK
        |=> stateReg == igcp_pkg::IGCP_LOCKED)
        else $error("broken key pair kept");

    locked_value_a: assert property (@(posedge clk) disable iff (sys_rst)
        !open |=> $stable(valReg) && $stable(indexReg))
        else $error("value or index changed while locked");

    open_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        open && !(idxWr && ioWrData == igcp_pkg::IGCP_KEY_LOCK) |=> open)
        else $error("unlocked state lost");

    index_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        open && idxWr && ioWrData != igcp_pkg::IGCP_KEY_LOCK |=> indexReg == $past(ioWrData))
        else $error("index not loaded");

    // Register writes land only where selected, reads return what was stored, and input value bits read the pin
    ldev_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        cfgWr && indexReg == igcp_pkg::IGCP_REG_LDEV |=> ldevReg == $past(ioWrData))
        else $error("device select not written");

    ldev_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        cfgRd && indexReg == igcp_pkg::IGCP_REG_LDEV |=> ioRdData == $past(ldevReg))
        else $error("device select read wrong");

    other_device_a: assert property (@(posedge clk) disable iff (sys_rst)
        cfgRd && ldevReg != igcp_pkg::IGCP_LDEV_GPIO && indexReg != igcp_pkg::IGCP_REG_LDEV
        |=> ioRdData == '0)
        else $error("pin register read with other device");

    dir_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        cfgWr && pinSel(indexReg, ldevReg, igcp_pkg::IGCP_REG_DIR)
        |=> dirReg == $past(ioWrData[PINS-1:0]))
        else $error("direction not written");

    output_value_a: assert property (@(posedge clk) disable iff (sys_rst)
        cfgWr && pinSel(indexReg, ldevReg, igcp_pkg::IGCP_REG_VALUE)
        |=> (valReg & ~$past(dirReg)) == ($past(ioWrData[PINS-1:0]) & ~$past(dirReg)))
        else $error("output value bit not written");

    output_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        cfgRd && pinSel(indexReg, ldevReg, igcp_pkg::IGCP_REG_VALUE)
        |=> (ioRdData[PINS-1:0] & ~$past(dirReg)) == ($past(valReg) & ~$past(dirReg)))
        else $error("output value read wrong");

    input_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        cfgRd && pinSel(indexReg, ldevReg, igcp_pkg::IGCP_REG_VALUE)
        |=> (ioRdData[PINS-1:0] & $past(dirReg))
            == ($past(pinLevelReg ^ polReg) & $past(dirReg)))
        else $error("input pin read wrong");

    pol_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        cfgWr && pinSel(indexReg, ldevReg, igcp_pkg::IGCP_REG_POL)
        |=> polReg == $past(ioWrData[PINS-1:0]))
        else $error("polarity not written");

    // A pin bit may only move when its second and third stages agreed
    pin_sample_a: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 ((pinLevelReg ^ $past(sync3Reg)) & ~$past(sync2Reg ^ sync3Reg)) == '0
        && ((pinLevelReg ^ $past(pinLevelReg)) & $past(sync2Reg ^ sync3Reg)) == '0)
        else $error("pin sample taken early");

endmodule : indexed_gpio_config_port

// ### testbench/igcp_pin_model.sv
// Pin-side model of the eight-pin bank.
// Assumes per-pin enable high while the bank drives the pin.
`timescale 1ns/1ps
module igcp_pin_model (
    input  wire logic [7:0] pinsOe,
    input  wire logic [7:0] pinsOut,
    input  wire logic [7:0] extLevel,
    output logic      [7:0] pinsIn
);
    // A driven pin shows its own drive, a released one the outside level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pinsIn[i] = pinsOe[i] ? pinsOut[i] : extLevel[i];
        end
    end
endmodule : igcp_pin_model

// ### testbench/indexed_gpio_config_port_bench.sv
// Self-checking bench for the indexed GPIO configuration port.
// Assumes one-cycle I/O strobes; inputs change at the falling edge.
`timescale 1ns/1ps
module indexed_gpio_config_port_bench;
    logic       clk;
    logic       sysRst;
    logic       ioWrite;
    logic       ioRead;
    logic       cfgUnlocked;
    logic [7:0] ioAddr;
    logic [7:0] ioWrData;
    logic [7:0] ioRdData;
    logic [7:0] pinsIn;
    logic [7:0] pinsOut;
    logic [7:0] pinsOe;
    logic [7:0] extLevel;
    logic [7:0] got;
    int         fails = 0;
    int         nTests = 0;
    ////////////////////////////////////////////////////////////////////////
    indexed_gpio_config_port #(.PINS(8)) i_dut (
        .clk(clk), .sys_rst(sysRst), .ioAddr(ioAddr), .ioWrite(ioWrite),
        .ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData),
        .cfgUnlocked(cfgUnlocked), .generalPinsIn(pinsIn),
        .generalPinsOut(pinsOut), .generalPinsOe(pinsOe));
    igcp_pin_model i_pins (
        .pinsOe(pinsOe), .pinsOut(pinsOut), .extLevel(extLevel), .pinsIn(pinsIn));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        nTests++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // One strobe per call; a read waits a cycle for the registered data
    task automatic io(input logic [7:0] a, input logic [7:0] d, input logic rd);
        @(negedge clk);
        ioAddr = a;
        ioWrData = d;
        ioWrite = !rd;
        ioRead = rd;
        @(negedge clk);
        ioWrite = 1'b0;
        ioRead = 1'b0;
        if (rd) begin
            @(negedge clk);
            got = ioRdData;
        end
    endtask : io
    task automatic cfg(input logic [7:0] idx, input logic [7:0] d);
        io(igcp_pkg::IGCP_ADDR_INDEX, idx, 1'b0);
        io(igcp_pkg::IGCP_ADDR_DATA, d, 1'b0);
    endtask : cfg
    task automatic cget(input logic [7:0] idx, input logic [7:0] e);
        io(igcp_pkg::IGCP_ADDR_INDEX, idx, 1'b0);
        io(igcp_pkg::IGCP_ADDR_DATA, 8'h00, 1'b1);
        chk(got, e);
    endtask : cget
    task automatic unlock();
        io(igcp_pkg::IGCP_ADDR_INDEX, igcp_pkg::IGCP_KEY_UNLOCK, 1'b0);
        io(igcp_pkg::IGCP_ADDR_INDEX, igcp_pkg::IGCP_KEY_UNLOCK, 1'b0);
    endtask : unlock
    task automatic close_out();
        $display("checks %0d mismatches %0d", nTests, fails);
        if (fails == 0 && nTests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////
    // Whole sequence is well under 1000 cycles
    initial begin
        #(3000 * 20);
        fails++;
        close_out();
    end
    initial begin
        sysRst = 1'b1;
        {ioWrite, ioRead, ioAddr, ioWrData} = '0;
        extLevel = 8'h3C;
        repeat (16) @(posedge clk);
        @(negedge clk);
        sysRst = 1'b0;
        io(8'h2F, 8'h00, 1'b1);
        chk(got, 8'hFF);
        io(8'h2E, 8'h87, 1'b0);
        io(8'h2E, 8'h07, 1'b0);
        chk({7'h0, cfgUnlocked}, 8'h00);
        unlock();
        chk({7'h0, cfgUnlocked}, 8'h01);
        $display("test unlock done");
        cfg(8'h07, 8'h07);
        cfg(8'hF0, 8'h00);
        cget(8'hF0, 8'h00);
        cfg(8'h07, 8'h09);
        cget(8'hF0, 8'hFF);
        cget(8'hF2, 8'h00);
        cget(8'hF1, 8'h3C);
        chk(pinsOe, 8'h00);
        $display("test select done");
        cfg(8'hF0, 8'h0F);
        cfg(8'hF1, 8'hA5);
        chk(pinsOe, 8'hF0);
        chk(pinsOut & 8'hF0, 8'hA0);
        cget(8'hF1, 8'hAC);
        $display("test direction done");
        cfg(8'hF2, 8'hFF);
        repeat (6) @(negedge clk);
        chk(pinsOut & 8'hF0, 8'h50);
        cget(8'hF1, 8'hA3);
        io(8'h2F, 8'h00, 1'b1);
        chk(got, 8'hA3);
        $display("test polarity done");
        io(8'h2E, 8'hAA, 1'b0);
        chk({7'h0, cfgUnlocked}, 8'h00);
        cfg(8'hF0, 8'hFF);
        io(8'h2F, 8'h00, 1'b1);
        chk(got, 8'hFF);
        unlock();
        cget(8'hF0, 8'h0F);
        cget(8'h07, 8'h09);
        cfg(8'hF0, 8'h00);
        chk(pinsOe, 8'hFF);
        chk(pinsOut, 8'h5F);
        $display("test lock done");
        @(negedge clk);
        sysRst = 1'b1;
        repeat (2) @(negedge clk);
        sysRst = 1'b0;
        chk(pinsOut, 8'h00);
        chk(pinsOe, 8'h00);
        chk({7'h0, cfgUnlocked}, 8'h00);
        unlock();
        cfg(8'h07, 8'h09);
        cget(8'hF0, 8'hFF);
        cget(8'hF2, 8'h00);
        $display("test reset done");
        close_out();
    end
endmodule : indexed_gpio_config_port_bench
